// >>> spi_nand_pkg.sv
package spi_nand_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Opcodes
   localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_PROG_LOAD     = 8'h02;
   localparam logic [7:0] OP_PROG_LOAD_X4  = 8'h32;
   localparam logic [7:0] OP_RAND_LOAD     = 8'h84;
   localparam logic [7:0] OP_RAND_LOAD_X4  = 8'h34;
   localparam logic [7:0] OP_PROG_EXECUTE  = 8'h10;
   localparam logic [7:0] OP_PAGE_READ     = 8'h13;
   localparam logic [7:0] OP_CACHE_READ    = 8'h03;
   localparam logic [7:0] OP_CACHE_READ_F  = 8'h0b;
   localparam logic [7:0] OP_GET_FEATURE   = 8'h0f;
   localparam logic [7:0] OP_SET_FEATURE   = 8'h1f;

   ////////////////////////////////////////////////////////////////////////////////
   // Features
   localparam logic [7:0] FEAT_CFG         = 8'hb0;
   localparam logic [7:0] FEAT_STATUS      = 8'hc0;
   localparam logic [7:0] CFG_SPECIAL_PAGE = 8'h40;
   localparam logic [7:0] CFG_RESET        = 8'h10;
   localparam int         STAT_BUSY_BIT    = 0;
   localparam int         STAT_LATCH_BIT   = 1;
   localparam int         STAT_PFAIL_BIT   = 3;

   ////////////////////////////////////////////////////////////////////////////////
   // Frame field lengths, as last bit index of each phase
   localparam logic [4:0] LAST_OPCODE      = 5'h07;
   localparam logic [4:0] LAST_COL_ADDR    = 5'h0f;
   localparam logic [4:0] LAST_ROW_ADDR    = 5'h17;
   localparam logic [4:0] LAST_FEAT_ADDR   = 5'h07;
   localparam logic [4:0] LAST_FEAT_SET    = 5'h0f;
   localparam logic [4:0] LAST_READ_ADDR   = 5'h17;
   localparam int         READ_COL_LSB     = 8;

   ////////////////////////////////////////////////////////////////////////////////
   // Cache and serial-number page geometry
   localparam int          COL_W           = 12;
   localparam int          CACHE_BYTES     = 2112;
   localparam logic [11:0] CACHE_LAST      = 12'h83f;
   localparam logic [11:0] SN_PAGE_BYTES   = 12'h200;
   localparam int          SN_ID_BYTES     = 16;
   localparam int          SN_REC_BYTES    = 32;

   ////////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int REF_CLK_MHZ   = 20;
   localparam int PROG_TIME_US  = 600;
   localparam int PROG_BUSY_CYC = PROG_TIME_US * REF_CLK_MHZ;
   localparam int READ_TIME_US  = 22;
   localparam int READ_BUSY_CYC = READ_TIME_US * REF_CLK_MHZ;
   localparam int CNT_W         = 14;

   ////////////////////////////////////////////////////////////////////////////////
   // Register port
   localparam logic [7:0]  REG_CTRL        = 8'h00;
   localparam logic [7:0]  REG_STATUS      = 8'h04;
   localparam logic [7:0]  REG_SN_ID0      = 8'h08;
   localparam logic [7:0]  REG_SN_ID1      = 8'h0c;
   localparam logic [7:0]  REG_SN_ID2      = 8'h10;
   localparam logic [7:0]  REG_SN_ID3      = 8'h14;
   localparam logic        CTRL_RESET      = 1'b0;
   localparam logic [127:0] SN_ID_RESET    = 128'h0;

   ////////////////////////////////////////////////////////////////////////////////
   // Frame states
   typedef enum logic [4:0] {
      ST_IDLE     = 5'b00001,
      ST_ADDR     = 5'b00010,
      ST_DATA_IN  = 5'b00100,
      ST_DATA_OUT = 5'b01000,
      ST_IGNORE   = 5'b10000
   } frame_e;

endpackage

// >>> cache_if.sv
`timescale 1ns/1ps
interface cache_if;
   import spi_nand_pkg::*;
   logic             clr;
   logic             wr_en;
   logic [COL_W-1:0] addr;
   logic [7:0]       wr_data;
   logic [7:0]       rd_data;

   modport ctrl (output clr, output wr_en, output addr, output wr_data, input rd_data);
   modport mem  (input clr, input wr_en, input addr, input wr_data, output rd_data);
endinterface

// >>> page_cache.sv
`timescale 1ns/1ps
module page_cache
   import spi_nand_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic rst_b,
   cache_if.mem      cif
);

   // A valid bit per byte lets a full FFh fill happen in one cycle
   logic [7:0]             mem_r [0:CACHE_BYTES-1];
   logic [CACHE_BYTES-1:0] valid_r;

   always_ff @(posedge ref_clk) begin
      if (cif.wr_en) begin
         mem_r[cif.addr] <= cif.wr_data;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         valid_r <= '0;
      end else if (cif.clr) begin
         valid_r <= '0;
      end else if (cif.wr_en) begin
         valid_r[cif.addr] <= 1'b1;
      end
   end

   always_comb begin
      cif.rd_data = 8'hff;
      if ((cif.addr <= CACHE_LAST) && valid_r[cif.addr]) begin
         cif.rd_data = mem_r[cif.addr];
      end
   end

endmodule

// >>> spi_nand_program_sequencer.sv
`timescale 1ns/1ps
module spi_nand_program_sequencer
   import spi_nand_pkg::*;
#(
   parameter int PROG_BUSY_CYCLES = PROG_BUSY_CYC
)
(
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   input  wire logic        spi_sck,
   input  wire logic        spi_cs_b,
   input  wire logic [3:0]  spi_io_in,
   output logic      [3:0]  spi_io_out,
   output logic      [3:0]  spi_io_oe,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   output logic             array_prog_strobe,
   output logic      [15:0] array_prog_row
);

   typedef struct packed {
      logic [5:0]       pin_s1;
      logic [5:0]       pin_s2;
      logic             sck_d;
      frame_e           st;
      logic [7:0]       op;
      logic [4:0]       bitcnt;
      logic [4:0]       last;
      logic [23:0]      sh;
      logic [COL_W-1:0] col;
      logic             over;
      logic [7:0]       fa;
      logic [7:0]       outbyte;
      logic [7:0]       cfg;
      logic             write_enable_latch;
      logic             busy;
      logic             prog_act;
      logic             pfail;
      logic [CNT_W-1:0] cnt;
      logic [15:0]      row;
      logic             sn_page;
      logic             fail_inj;
      logic [127:0]     sn_id;
      logic [31:0]      rdata;
      logic [3:0]       io_out;
      logic [3:0]       io_oe;
      logic             prog_strobe;
   } core_s;

   core_s s_r;
   core_s s_nxt;

   cache_if cif ();

   page_cache u_cache (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .cif     (cif)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Decoded link view, taken from the second synchroniser stage only
   logic       cs_hi;
   logic       sck_rise;
   logic       sck_fall;
   logic [3:0] io;
   logic       quad;
   logic       is_load;
   logic [7:0] status_byte;
   logic [7:0] feat_val;
   logic [7:0] id_byte;
   logic [7:0] sn_val;
   logic [7:0] byte_val;
   logic [7:0] opv;

   assign cs_hi    = s_r.pin_s2[5];
   assign sck_rise = s_r.pin_s2[4] & ~s_r.sck_d;
   assign sck_fall = ~s_r.pin_s2[4] & s_r.sck_d;
   assign io       = s_r.pin_s2[3:0];
   assign opv      = {s_r.sh[6:0], io[0]};
   assign quad     = (s_r.op == OP_PROG_LOAD_X4) || (s_r.op == OP_RAND_LOAD_X4);
   assign is_load  = (s_r.op == OP_PROG_LOAD) || (s_r.op == OP_PROG_LOAD_X4) ||
                     (s_r.op == OP_RAND_LOAD) || (s_r.op == OP_RAND_LOAD_X4);

   assign status_byte = {4'h0, s_r.pfail, 1'b0, s_r.write_enable_latch, s_r.busy};
   assign feat_val    = (s_r.fa == FEAT_STATUS) ? status_byte :
                        (s_r.fa == FEAT_CFG)    ? s_r.cfg     : 8'h00;

   // records of identifier bytes then their complement
   assign id_byte  = s_r.sn_id[{s_r.col[3:0], 3'b000} +: 8];
   assign sn_val   = (s_r.col < SN_PAGE_BYTES) ? (s_r.col[4] ? ~id_byte : id_byte) : 8'h00;
   assign byte_val = (s_r.op == OP_GET_FEATURE) ? feat_val :
                     s_r.sn_page                ? sn_val   : cif.rd_data;

   // data write at the current column
   assign cif.addr    = s_r.col;
   assign cif.wr_data = quad ? {s_r.sh[3:0], io} : {s_r.sh[6:0], io[0]};

   ////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      s_nxt             = s_r;
      cif.clr           = 1'b0;
      cif.wr_en         = 1'b0;
      s_nxt.pin_s1      = {spi_cs_b, spi_sck, spi_io_in};
      s_nxt.pin_s2      = s_r.pin_s1;
      s_nxt.sck_d       = s_r.pin_s2[4];
      s_nxt.prog_strobe = 1'b0;
      s_nxt.rdata       = 32'h0;

      if (s_r.busy) begin
         if (s_r.cnt <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
            s_nxt.busy = 1'b0;
            if (s_r.prog_act) begin
               s_nxt.prog_act           = 1'b0;
               s_nxt.write_enable_latch = 1'b0;
               s_nxt.pfail    = s_r.fail_inj;
            end
         end else begin
            s_nxt.cnt = s_r.cnt - 1'b1;
         end
      end

      // frame ends at chip select high
      if (cs_hi) begin
         s_nxt.st     = ST_IDLE;
         s_nxt.bitcnt = 5'h00;
         s_nxt.io_oe  = 4'h0;
         s_nxt.io_out = 4'h0;
      end else if (sck_rise) begin
         case (s_r.st)
            ST_IDLE: begin
               s_nxt.sh = {s_r.sh[22:0], io[0]};
               if (s_r.bitcnt == LAST_OPCODE) begin
                  s_nxt.op     = opv;
                  s_nxt.bitcnt = 5'h00;
                  s_nxt.st     = ST_IGNORE;
                  // Only Get Feature, for any feature address, is served while the array is busy
                  if (!s_r.busy || (opv == OP_GET_FEATURE)) begin
                     case (opv)
                        OP_WRITE_ENABLE: begin
                           s_nxt.write_enable_latch = 1'b1;
                        end
                        OP_WRITE_DISABLE: begin
                           s_nxt.write_enable_latch = 1'b0;
                        end
                        OP_PROG_LOAD, OP_PROG_LOAD_X4, OP_RAND_LOAD, OP_RAND_LOAD_X4: begin
                           if (s_r.write_enable_latch) begin
                              s_nxt.st      = ST_ADDR;
                              s_nxt.last    = LAST_COL_ADDR;
                              s_nxt.sn_page = 1'b0;
                              cif.clr = (opv == OP_PROG_LOAD) || (opv == OP_PROG_LOAD_X4);
                           end
                        end
                        OP_PROG_EXECUTE: begin
                           if (s_r.write_enable_latch) begin
                              s_nxt.st   = ST_ADDR;
                              s_nxt.last = LAST_ROW_ADDR;
                           end
                        end
                        OP_PAGE_READ: begin
                           s_nxt.st   = ST_ADDR;
                           s_nxt.last = LAST_ROW_ADDR;
                        end
                        OP_CACHE_READ, OP_CACHE_READ_F: begin
                           s_nxt.st   = ST_ADDR;
                           s_nxt.last = LAST_READ_ADDR;
                        end
                        OP_GET_FEATURE: begin
                           s_nxt.st   = ST_ADDR;
                           s_nxt.last = LAST_FEAT_ADDR;
                        end
                        OP_SET_FEATURE: begin
                           s_nxt.st   = ST_ADDR;
                           s_nxt.last = LAST_FEAT_SET;
                        end
                        default: begin
                           s_nxt.st = ST_IGNORE;
                        end
                     endcase
                  end
               end else begin
                  s_nxt.bitcnt = s_r.bitcnt + 1'b1;
               end
            end
            ST_ADDR: begin
               s_nxt.sh = {s_r.sh[22:0], io[0]};
               if (s_r.bitcnt == s_r.last) begin
                  s_nxt.bitcnt = 5'h00;
                  s_nxt.st     = ST_IGNORE;
                  if (is_load) begin
                     s_nxt.col  = s_nxt.sh[COL_W-1:0];
                     s_nxt.over = (s_nxt.sh[COL_W-1:0] > CACHE_LAST);
                     s_nxt.st   = ST_DATA_IN;
                  end else if (s_r.op == OP_PROG_EXECUTE) begin
                     s_nxt.row         = s_nxt.sh[15:0];
                     // start array program and report busy
                     s_nxt.busy        = 1'b1;
                     s_nxt.prog_act    = 1'b1;
                     s_nxt.pfail       = 1'b0;
                     s_nxt.cnt         = CNT_W'(PROG_BUSY_CYCLES);
                     s_nxt.prog_strobe = 1'b1;
                  end else if (s_r.op == OP_PAGE_READ) begin
                     s_nxt.row     = s_nxt.sh[15:0];
                     s_nxt.busy    = 1'b1;
                     s_nxt.cnt     = CNT_W'(READ_BUSY_CYC);
                     // special page selected by config and page zero
                     s_nxt.sn_page = (s_r.cfg == CFG_SPECIAL_PAGE) && (s_nxt.sh[15:0] == 16'h0);
                  end else if (s_r.op == OP_GET_FEATURE) begin
                     s_nxt.fa = s_nxt.sh[7:0];
                     s_nxt.st = ST_DATA_OUT;
                  end else if (s_r.op == OP_SET_FEATURE) begin
                     if (s_nxt.sh[15:8] == FEAT_CFG) begin
                        s_nxt.cfg = s_nxt.sh[7:0];
                     end
                  end else begin
                     s_nxt.col = s_nxt.sh[READ_COL_LSB +: COL_W];
                     s_nxt.st  = ST_DATA_OUT;
                  end
               end else begin
                  s_nxt.bitcnt = s_r.bitcnt + 1'b1;
               end
            end
            ST_DATA_IN: begin
               s_nxt.sh = {s_r.sh[23:8], cif.wr_data};
               if (s_r.bitcnt == (quad ? 5'h01 : 5'h07)) begin
                  s_nxt.bitcnt = 5'h00;
                  if (!s_r.over) begin
                     cif.wr_en  = 1'b1;
                     s_nxt.col  = s_r.col + 1'b1;
                     s_nxt.over = (s_r.col == CACHE_LAST);
                  end
               end else begin
                  s_nxt.bitcnt = s_r.bitcnt + 1'b1;
               end
            end
            ST_DATA_OUT: begin
               if (s_r.bitcnt == 5'h07) begin
                  s_nxt.bitcnt = 5'h00;
                  s_nxt.col    = s_r.col + 1'b1;
               end else begin
                  s_nxt.bitcnt = s_r.bitcnt + 1'b1;
               end
            end
            ST_IGNORE: begin
               s_nxt.st = ST_IGNORE;
            end
            default: begin
               s_nxt.st = ST_IGNORE;
            end
         endcase
      end else if (sck_fall && (s_r.st == ST_DATA_OUT)) begin
         // shift out on the falling edge, byte fetched at its first bit
         s_nxt.outbyte   = (s_r.bitcnt == 5'h00) ? byte_val : s_r.outbyte;
         s_nxt.io_out[1] = s_nxt.outbyte[3'd7 - s_r.bitcnt[2:0]];
         s_nxt.io_oe     = 4'b0010;
      end

      // Register port
      if (reg_wr) begin
         case (reg_addr)
            REG_CTRL:   s_nxt.fail_inj       = reg_wdata[0];
            REG_SN_ID0: s_nxt.sn_id[31:0]    = reg_wdata;
            REG_SN_ID1: s_nxt.sn_id[63:32]   = reg_wdata;
            REG_SN_ID2: s_nxt.sn_id[95:64]   = reg_wdata;
            REG_SN_ID3: s_nxt.sn_id[127:96]  = reg_wdata;
            default:    s_nxt.fail_inj       = s_r.fail_inj;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            REG_CTRL:   s_nxt.rdata = {31'h0, s_r.fail_inj};
            REG_STATUS: s_nxt.rdata = {8'h0, 2'h0, s_r.sn_page, s_r.st, s_r.cfg, status_byte};
            REG_SN_ID0: s_nxt.rdata = s_r.sn_id[31:0];
            REG_SN_ID1: s_nxt.rdata = s_r.sn_id[63:32];
            REG_SN_ID2: s_nxt.rdata = s_r.sn_id[95:64];
            REG_SN_ID3: s_nxt.rdata = s_r.sn_id[127:96];
            default:    s_nxt.rdata = 32'h0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_r          <= '0;
         s_r.pin_s1   <= 6'h20;
         s_r.pin_s2   <= 6'h20;
         s_r.st       <= ST_IDLE;
         s_r.cfg      <= CFG_RESET;
         s_r.fail_inj <= CTRL_RESET;
         s_r.sn_id    <= SN_ID_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign spi_io_out        = s_r.io_out;
   assign spi_io_oe         = s_r.io_oe;
   assign reg_rdata         = s_r.rdata;
   assign array_prog_strobe = s_r.prog_strobe;
   assign array_prog_row    = s_r.row;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   AST_LOAD_NEEDS_LATCH: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (s_r.st != ST_DATA_IN) ##1 (s_r.st == ST_DATA_IN) |-> s_r.write_enable_latch)
      else $error("load accepted without write enable latch");

   AST_EXEC_NEEDS_LATCH: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $rose(s_r.prog_act) |-> $past(s_r.write_enable_latch))
      else $error("program started without write enable latch");

   AST_CACHE_BOUND: assert property (@(posedge ref_clk) disable iff (!rst_b)
      cif.wr_en |-> (cif.addr <= CACHE_LAST) && (s_r.st == ST_DATA_IN))
      else $error("cache written beyond capacity");

   AST_CS_ENDS_FRAME: assert property (@(posedge ref_clk) disable iff (!rst_b)
      cs_hi |=> (s_r.st == ST_IDLE) && !cif.wr_en && (s_r.io_oe == 4'h0))
      else $error("frame continued after chip select high");

   AST_PROG_BUSY_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $rose(s_r.prog_act) |-> s_r.busy && s_r.prog_strobe ##1 (s_r.busy && !s_r.prog_strobe)[*8])
      else $error("program busy not held after row capture");

   AST_PROG_DONE: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $fell(s_r.busy) && $past(s_r.prog_act) |->
         !s_r.write_enable_latch && (s_r.pfail == $past(s_r.fail_inj)))
      else $error("program completion report wrong");

   AST_CLEAR_PLAIN_ONLY: assert property (@(posedge ref_clk) disable iff (!rst_b)
      cif.clr |-> s_r.write_enable_latch && !s_r.busy && sck_rise && (s_r.st == ST_IDLE) &&
         ((opv == OP_PROG_LOAD) || (opv == OP_PROG_LOAD_X4)))
      else $error("cache fill outside a plain load opcode");

   AST_QUAD_NIBBLES: assert property (@(posedge ref_clk) disable iff (!rst_b)
      cif.wr_en && quad |-> (s_r.bitcnt == 5'h01))
      else $error("quad byte not built from two nibbles");

   AST_ROW_CAPTURE: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_r.prog_strobe |-> (array_prog_row == s_r.sh[15:0]) && (s_r.op == OP_PROG_EXECUTE))
      else $error("execute row not captured");

endmodule

// >>> spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
   input  wire logic       ref_clk,
   input  wire logic [3:0] dev_out,
   output logic            sck,
   output logic            cs_b,
   output logic      [3:0] io
);
   initial begin
      sck = 1'b0;
      cs_b = 1'b1;
      io = 4'h0;
   end
   // Five cycles a phase keeps sck inside the synchroniser limit
   task automatic half();
      repeat (5) @(posedge ref_clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // MSB first shifting
   task automatic shift(input logic [31:0] v, input int n, input bit q);
      for (int i = n - 1; i >= 0; i -= (q ? 4 : 1)) begin
         cs_b <= 1'b0;
         sck  <= 1'b0;
         io   <= q ? v[i-:4] : {~io[3:1], v[i]};
         half();
         sck  <= 1'b1;
         half();
      end
   endtask
   task automatic recv(output logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         sck <= 1'b0;
         half();
         sck <= 1'b1;
         b = {b[6:0], dev_out[1]};
         half();
      end
   endtask
   task automatic stop();
      sck  <= 1'b0;
      half();
      cs_b <= 1'b1;
      io   <= ~io;
      half();
   endtask
endmodule

// >>> spi_nand_program_sequencer_bench.sv
`timescale 1ns/1ps
module spi_nand_program_sequencer_bench;
   import spi_nand_pkg::*;
   logic         ref_clk = 1'b0;
   logic         rst_b = 1'b0;
   logic         sck, cs_b, strobe;
   logic         reg_wr = 1'b0;
   logic         reg_rd = 1'b0;
   logic [7:0]   reg_addr = 8'h00;
   logic [31:0]  reg_wdata = 32'h0;
   logic [3:0]   io, out, oe;
   logic [31:0]  rdata, r, d;
   logic [15:0]  prow, row;
   logic [127:0] ids;
   logic [7:0]   b;
   int           failures = 0;
   int           samples_checked = 0;
   int           strobes = 0;
   always #25 ref_clk = ~ref_clk;
   spi_nand_program_sequencer #(.PROG_BUSY_CYCLES(50)) i_spi_nand_program_sequencer (
      .ref_clk(ref_clk), .rst_b(rst_b), .spi_sck(sck), .spi_cs_b(cs_b), .spi_io_in(io),
      .spi_io_out(out), .spi_io_oe(oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .array_prog_strobe(strobe),
      .array_prog_row(prow));
   spi_host_model i_spi_host_model (
      .ref_clk(ref_clk), .dev_out(out), .sck(sck), .cs_b(cs_b), .io(io));
   always @(posedge ref_clk) begin
      if (strobe === 1'b1) strobes <= strobes + 1;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask
   task automatic rreg(input logic [7:0] a);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      #1 r = rdata;
   endtask
   task automatic cmd(input logic [7:0] op, input logic [31:0] a, input int na,
                      input logic [31:0] v, input int nd, input bit q);
      i_spi_host_model.shift(op, 8, 0);
      i_spi_host_model.shift(a, na, 0);
      i_spi_host_model.shift(v, nd, q);
      i_spi_host_model.stop();
   endtask
   task automatic poll();
      logic [7:0] s;
      for (int k = 0; k < 40; k++) begin
         // Status byte must be read inside the same frame as its address
         i_spi_host_model.shift(OP_GET_FEATURE, 8, 0);
         i_spi_host_model.shift(FEAT_STATUS, 8, 0);
         i_spi_host_model.recv(s);
         i_spi_host_model.stop();
         if (s[STAT_BUSY_BIT] === 1'b0) return;
      end
      chk("busy", 32'h0, {31'h0, s[STAT_BUSY_BIT]});
   endtask
   // Serial page byte: identifier byte, complemented in the odd half of each record
   function automatic logic [7:0] sn(input int c);
      logic [7:0] v;
      v = ids[8*(c%16) +: 8];
      return c[4] ? ~v : v;
   endfunction
   task automatic rdc(input logic [11:0] col, input int n, input bit snp, input logic [31:0] e);
      logic [7:0] rec [16];
      i_spi_host_model.shift(OP_CACHE_READ, 8, 0);
      i_spi_host_model.shift({4'h0, col, 8'h00}, 24, 0);
      for (int i = 0; i < n; i++) begin
         i_spi_host_model.recv(b);
         chk("cache byte", snp ? sn(i) : e[8*(n-1-i) +: 8], {24'h0, b});
         if (snp && i[4]) begin
            chk("record xor", 32'hff, {24'h0, b ^ rec[i%16]});
         end
         rec[i%16] = b;
      end
      chk("output enable", 32'h2, {28'h0, oe});
      i_spi_host_model.stop();
      chk("output released", 32'h0, {28'h0, oe});
   endtask
   task automatic final_report();
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Whole sequence needs about 14k cycles
   initial begin
      repeat (60000) @(posedge ref_clk);
      failures++;
      final_report();
   end
   initial begin
      void'($urandom(32'h07943fb0));
      repeat (20) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rreg(REG_STATUS);
      chk("status", {11'h0, ST_IDLE, CFG_RESET, 8'h00}, r);
      wreg(8'hfc, 32'hffffffff);
      rreg(8'hfc);
      chk("unmapped", 32'h0, r);
      ids = {$urandom, $urandom, $urandom, $urandom};
      for (int k = 0; k < 4; k++) wreg(REG_SN_ID0 + 8'(4 * k), ids[32*k +: 32]);
      $display("test registers done");
      cmd(OP_SET_FEATURE, {FEAT_CFG, CFG_SPECIAL_PAGE}, 16, 0, 0, 0);
      cmd(OP_PAGE_READ, 32'h0, 24, 0, 0, 0);
      poll();
      rdc(12'h0, 64, 1, 0);
      cmd(OP_SET_FEATURE, {FEAT_CFG, CFG_RESET}, 16, 0, 0, 0);
      $display("test serial page done");
      d = $urandom;
      row = 16'($urandom);
      wreg(REG_CTRL, 32'h1);
      cmd(OP_WRITE_ENABLE, 0, 0, 0, 0, 0);
      cmd(OP_PROG_LOAD_X4, {4'h0, CACHE_LAST - 12'h1}, 16, d, 32, 1);
      cmd(OP_PROG_EXECUTE, {8'h00, row}, 24, 0, 0, 0);
      rreg(REG_STATUS);
      chk("busy status", 32'h3, {24'h0, r[7:0]});
      chk("row", {16'h0, row}, {16'h0, prow});
      chk("strobes", 32'd1, 32'(strobes));
      poll();
      rreg(REG_STATUS);
      chk("done status", 32'h8, {24'h0, r[7:0]});
      rdc(CACHE_LAST - 12'h1, 2, 0, {16'h0, d[31:16]});
      rdc(12'h0, 1, 0, 32'hff);
      $display("test quad program done");
      wreg(REG_CTRL, 32'h0);
      // source and target page share the one die
      cmd(OP_PAGE_READ, {8'h00, row}, 24, 0, 0, 0);
      poll();
      cmd(OP_WRITE_ENABLE, 0, 0, 0, 0, 0);
      cmd(OP_RAND_LOAD, 32'h1, 16, d, 8, 0);
      cmd(OP_RAND_LOAD_X4, 32'h3, 16, d[15:8], 8, 1);
      // this row sees its second program, inside the limit of four
      cmd(OP_PROG_EXECUTE, {8'h00, row}, 24, 0, 0, 0);
      poll();
      rreg(REG_STATUS);
      chk("done status", 32'h0, {24'h0, r[7:0]});
      rdc(12'h0, 4, 0, {8'hff, d[7:0], 8'hff, d[15:8]});
      rdc(CACHE_LAST - 12'h1, 2, 0, {16'h0, d[31:16]});
      $display("test random program done");
      cmd(OP_WRITE_ENABLE, 0, 0, 0, 0, 0);
      cmd(OP_WRITE_DISABLE, 0, 0, 0, 0, 0);
      cmd(OP_PROG_LOAD, 32'h0, 16, 32'h0, 8, 0);
      cmd(OP_PROG_EXECUTE, {8'h00, row}, 24, 0, 0, 0);
      chk("strobes", 32'd2, 32'(strobes));
      rdc(12'h0, 2, 0, {16'h0, 8'hff, d[7:0]});
      $display("test no write enable done");
      final_report();
   end
endmodule
